// file: rail_target.sv
// Behaviour
// - answer only address 0111110 with write bit
// - reads refused, never return register contents
// - sub-address 00h: positive level, bits 4:0
// - sub-address 01h: negative level, bits 4:0
// - controller keeps mode bits 0,1 set
// - codes 1..17 give 4.1..5.7 V; 0 unused
// - standby: port inactive, bus ignored
// - bytes of eight, ack low after eighth fall
// - any byte count, sub-address auto increments
// - first byte: address msb first, write bit
// - start and stop detected while SCL high
// - controller keeps SDA stable while SCL high
// - supports SCL up to 400 kHz
// - high codes only 45 ms after enables
// - defaults rewritten before enables drop
// - reset returns all logic to initial state
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rail_port_params.svh"

module rail_target
	import rail_port_pkg::*;
#(
	parameter bit HIGH_DEFAULT = 1'b0
) (
	// clock, reset, enable
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                ce,
	// power state
	input  wire logic                standby,
	// serial link
	rail_link_if.tgt                 link,
	// register contents
	output logic [`LEVEL_MSB:0]      positive_rail,
	output logic [`LEVEL_MSB:0]      negative_rail,
	output logic [7:0]               mode_bits,
	output logic                     level_write
);

	localparam logic [`LEVEL_MSB:0] DEF_CODE =
		HIGH_DEFAULT ? `DEF_CODE_HI : `DEF_CODE_LO;

	// pin synchronisers, three stages each
	logic [2:0]          scl_sync_r;
	logic [2:0]          sda_sync_r;
	logic                scl_f_r;
	logic                sda_f_r;
	logic                scl_prev_r;
	logic                sda_prev_r;

	// protocol state
	target_state_t       state_r;
	target_state_t       state_nxt;
	logic [3:0]          cnt_r;
	logic [7:0]          shift_r;
	logic [7:0]          ptr_r;
	logic                ack_r;

	// register file
	logic [`LEVEL_MSB:0] pos_r;
	logic [`LEVEL_MSB:0] neg_r;
	logic [7:0]          mode_r;
	logic                wr_pulse_r;

	// decoded events
	wire scl_rise   = scl_f_r & ~scl_prev_r;
	wire scl_fall   = ~scl_f_r & scl_prev_r;
	wire start_ev   = scl_f_r & scl_prev_r & sda_prev_r & ~sda_f_r;
	wire stop_ev    = scl_f_r & scl_prev_r & ~sda_prev_r & sda_f_r;
	wire byte_done  = scl_fall & (cnt_r == 4'd8) & ~ack_r;
	wire ack_done   = scl_fall & ack_r;
	wire addr_match = (shift_r == {`TGT_ADDR, `DIR_WRITE});
	wire wr_data    = byte_done & (state_r == T_DATA);
	wire hit_pos    = wr_data & (ptr_r == `SUB_POS);
	wire hit_neg    = wr_data & (ptr_r == `SUB_NEG);
	wire hit_mode   = wr_data & (ptr_r == `SUB_MODE);
	wire take_byte  = byte_done & (state_r != T_SKIP)
		& (state_r != T_IDLE)
		& ((state_r != T_ADDR) | addr_match);

	// synchronise scl and sda; a level counts once stages two and three agree
	always_ff @(posedge clock) begin
		if (rst) begin
			scl_sync_r <= 3'h7;
			sda_sync_r <= 3'h7;
			scl_f_r    <= 1'b1;
			sda_f_r    <= 1'b1;
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else if (ce) begin
			scl_sync_r <= {scl_sync_r[1:0], link.scl};
			sda_sync_r <= {sda_sync_r[1:0], link.sda};
			if (scl_sync_r[1] == scl_sync_r[2])
				scl_f_r <= scl_sync_r[2];
			if (sda_sync_r[1] == sda_sync_r[2])
				sda_f_r <= sda_sync_r[2];
			scl_prev_r <= scl_f_r;
			sda_prev_r <= sda_f_r;
		end
	end

	// next protocol state
	always_comb begin
		state_nxt = state_r;
		if (standby) begin
			state_nxt = T_IDLE;
		end else if (start_ev) begin
			state_nxt = T_ADDR;
		end else if (stop_ev) begin
			state_nxt = T_IDLE;
		end else if (byte_done) begin
			case (state_r)
				T_ADDR: begin
					state_nxt = addr_match ? T_SUB : T_SKIP;
				end
				T_SUB: begin
					state_nxt = T_DATA;
				end
				T_DATA: begin
					state_nxt = T_DATA;
				end
				default: begin
					state_nxt = state_r;
				end
			endcase
		end
	end

	// state, bit counter and shift register
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= T_IDLE;
			cnt_r   <= 4'h0;
			shift_r <= 8'h00;
		end else if (ce) begin
			state_r <= state_nxt;
			if (standby | start_ev | stop_ev) begin
				cnt_r <= 4'h0;
			end else if (scl_rise & (cnt_r < 4'd8)) begin
				shift_r <= {shift_r[6:0], sda_f_r};
				cnt_r   <= cnt_r + 4'd1;
			end else if (byte_done | ack_done) begin
				cnt_r <= 4'h0;
			end
		end
	end

	// acknowledge: low from the eighth fall to the ninth
	always_ff @(posedge clock) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else if (ce) begin
			if (standby | start_ev | stop_ev)
				ack_r <= 1'b0;
			else if (take_byte)
				ack_r <= 1'b1;
			else if (ack_done)
				ack_r <= 1'b0;
		end
	end

	// sub-address pointer
	always_ff @(posedge clock) begin
		if (rst) begin
			ptr_r <= 8'h00;
		end else if (ce) begin
			if (byte_done & (state_r == T_SUB))
				ptr_r <= shift_r;
			else if (wr_data)
				ptr_r <= ptr_r + 8'h01;
		end
	end

	// register file writes
	always_ff @(posedge clock) begin
		if (rst) begin
			pos_r      <= DEF_CODE;
			neg_r      <= DEF_CODE;
			mode_r     <= `MODE_RESET;
			wr_pulse_r <= 1'b0;
		end else if (ce) begin
			wr_pulse_r <= hit_pos | hit_neg;
			if (hit_pos)
				pos_r <= shift_r[`LEVEL_MSB:0];
			if (hit_neg)
				neg_r <= shift_r[`LEVEL_MSB:0];
			if (hit_mode)
				mode_r <= shift_r;
		end
	end

	// link drive: only ever pulls sda low for acknowledge
	assign link.sda_tgt_o  = 1'b0;
	assign link.sda_tgt_oe = ack_r;

	// user-side outputs
	assign positive_rail = pos_r;
	assign negative_rail = neg_r;
	assign mode_bits     = mode_r;
	assign level_write   = wr_pulse_r;

endmodule // rail_target

`default_nettype wire

// file: rail_port_params.svh
`ifndef RAIL_PORT_PARAMS_SVH
`define RAIL_PORT_PARAMS_SVH

// serial link addressing
`define TGT_ADDR        7'h3e
`define DIR_WRITE       1'b0
`define SUB_POS         8'h00
`define SUB_NEG         8'h01
`define SUB_MODE        8'h03

// register field layout and reset values
`define LEVEL_MSB       4
`define LEVEL_W         5
`define DEF_CODE_LO     5'h0a
`define DEF_CODE_HI     5'h0e
`define MODE_RESET      8'h03

// link timing; rate kept under 400 kHz so each low phase lasts at least 1.3 us
`define CLK_HZ          40000000
`define SCL_HZ          370000
`define QUARTER_CYC     (`CLK_HZ / (4 * `SCL_HZ))

// controller register map
`define CTL_CMD         8'h00
`define CTL_STATUS      8'h04
`define ST_BUSY         0
`define ST_NACK         1

`endif

// file: rail_port_pkg.sv
`default_nettype none

package rail_port_pkg;

	// target side states
	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_ADDR = 3'b001,
		T_SUB  = 3'b010,
		T_DATA = 3'b011,
		T_SKIP = 3'b100
	} target_state_t;

	// controller side states
	typedef enum logic [1:0] {
		C_IDLE  = 2'b00,
		C_START = 2'b01,
		C_BIT   = 2'b10,
		C_STOP  = 2'b11
	} ctl_state_t;

endpackage

`default_nettype wire

// file: rail_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rail_link_if;
	// controller drives
	logic scl_o;
	logic scl_oe;
	logic sda_ctl_o;
	logic sda_ctl_oe;
	// target drives
	logic sda_tgt_o;
	logic sda_tgt_oe;
	// resolved open-drain levels, pulled high when nobody drives
	logic scl;
	logic sda;

	assign scl = scl_oe ? scl_o : 1'b1;
	assign sda = (sda_ctl_oe ? sda_ctl_o : 1'b1)
		& (sda_tgt_oe ? sda_tgt_o : 1'b1);

	modport ctl (
		output scl_o,
		output scl_oe,
		output sda_ctl_o,
		output sda_ctl_oe,
		input  scl,
		input  sda
	);

	modport tgt (
		output sda_tgt_o,
		output sda_tgt_oe,
		input  scl,
		input  sda
	);
endinterface

`default_nettype wire

// file: rail_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "rail_port_params.svh"

module rail_controller
	import rail_port_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	// software register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// serial link
	rail_link_if.ctl         link
);

	localparam logic [7:0] QUARTER = 8'(`QUARTER_CYC);

	// sda synchroniser
	logic [2:0]  sda_sync_r;
	logic        sda_f_r;

	// sequencer
	ctl_state_t  state_r;
	logic [7:0]  div_r;
	logic [1:0]  phase_r;
	logic [3:0]  bit_r;
	logic [1:0]  byte_r;
	logic [7:0]  sub_r;
	logic [7:0]  data_r;
	logic        nack_r;
	logic        scl_low_r;
	logic        sda_low_r;
	logic [31:0] rdata_r;

	// decode
	wire        busy     = (state_r != C_IDLE);
	wire        tick     = busy & (div_r == QUARTER - 8'h01);
	wire        cmd_wr   = wr & (addr == `CTL_CMD) & ~busy;
	wire        stat_rd  = rd & (addr == `CTL_STATUS);
	wire [7:0]  cur_byte = (byte_r == 2'd0) ? {`TGT_ADDR, `DIR_WRITE} :
		(byte_r == 2'd1) ? sub_r : data_r;
	wire        cur_bit  = cur_byte[3'd7 - bit_r[2:0]];
	wire        ack_slot = (bit_r == 4'd8);

	// sda input, three stages with agreement filter
	always_ff @(posedge clock) begin
		if (rst) begin
			sda_sync_r <= 3'h7;
			sda_f_r    <= 1'b1;
		end else if (ce) begin
			sda_sync_r <= {sda_sync_r[1:0], link.sda};
			if (sda_sync_r[1] == sda_sync_r[2])
				sda_f_r <= sda_sync_r[2];
		end
	end

	// quarter-period divider for the generated scl
	always_ff @(posedge clock) begin
		if (rst) begin
			div_r <= 8'h00;
		end else if (ce) begin
			if (~busy | tick)
				div_r <= 8'h00;
			else
				div_r <= div_r + 8'h01;
		end
	end

	// command capture and read port
	always_ff @(posedge clock) begin
		if (rst) begin
			sub_r   <= 8'h00;
			data_r  <= 8'h00;
			rdata_r <= 32'h0;
		end else if (ce) begin
			if (cmd_wr) begin
				sub_r  <= wdata[7:0];
				data_r <= wdata[15:8];
			end
			rdata_r <= stat_rd ? {30'h0, nack_r, busy} : 32'h0;
		end
	end

	// bus sequencer: start, up to three bytes with ack slots (stops after a nack), stop
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r   <= C_IDLE;
			phase_r   <= 2'd0;
			bit_r     <= 4'h0;
			byte_r    <= 2'd0;
			nack_r    <= 1'b0;
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
		end else if (ce) begin
			if (cmd_wr) begin
				state_r <= C_START;
				phase_r <= 2'd0;
				bit_r   <= 4'h0;
				byte_r  <= 2'd0;
				nack_r  <= 1'b0;
			end else if (tick) begin
				phase_r <= phase_r + 2'd1;
				case (state_r)
					C_START: begin
						if (phase_r == 2'd0)
							sda_low_r <= 1'b1;
						if (phase_r == 2'd1) begin
							scl_low_r <= 1'b1;
							state_r   <= C_BIT;
							phase_r   <= 2'd0;
						end
					end
					C_BIT: begin
						if (phase_r == 2'd0)
							sda_low_r <= ~ack_slot & ~cur_bit;
						if (phase_r == 2'd1)
							scl_low_r <= 1'b0;
						if ((phase_r == 2'd2) & ack_slot & sda_f_r)
							nack_r <= 1'b1;
						if (phase_r == 2'd3) begin
							scl_low_r <= 1'b1;
							if (~ack_slot) begin
								bit_r <= bit_r + 4'h1;
							end else begin
								bit_r <= 4'h0;
								if (nack_r | (byte_r == 2'd2))
									state_r <= C_STOP;
								else
									byte_r <= byte_r + 2'd1;
							end
						end
					end
					C_STOP: begin
						if (phase_r == 2'd0)
							sda_low_r <= 1'b1;
						if (phase_r == 2'd1)
							scl_low_r <= 1'b0;
						if (phase_r == 2'd2)
							sda_low_r <= 1'b0;
						if (phase_r == 2'd3)
							state_r <= C_IDLE;
					end
					default: begin
						state_r <= C_IDLE;
					end
				endcase
			end
		end
	end

	// open-drain drive, writes only
	assign link.scl_o      = 1'b0;
	assign link.scl_oe     = scl_low_r;
	assign link.sda_ctl_o  = 1'b0;
	assign link.sda_ctl_oe = sda_low_r;
	assign rdata           = rdata_r;

endmodule // rail_controller

`default_nettype wire

// file: rail_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module rail_link_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// resolved lines and their drivers
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_oe,
	input wire logic sda_ctl_oe,
	input wire logic sda_tgt_oe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// bus conditions seen on the wire
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	sequence s_ack_on;
		$rose(sda_tgt_oe);
	endsequence

	// both lines released once reset ends
	chk_idle_after_rst: assert property ($fell(rst) |-> scl && sda
		&& !scl_oe && !sda_ctl_oe && !sda_tgt_oe)
		else $error("lines not idle after reset");
	// acknowledge starts only while the clock is low
	chk_ack_in_low: assert property (s_ack_on |-> !scl)
		else $error("ack raised with clock high");
	chk_ack_held_high: assert property ($rose(scl) && sda_tgt_oe
		|-> sda_tgt_oe[*8])
		else $error("ack dropped during clock high");
	chk_ack_bounded: assert property (s_ack_on |-> ##[1:200] !sda_tgt_oe)
		else $error("ack held too long");
	// framing conditions
	chk_start_clocks: assert property (s_start |-> ##[1:60] !scl)
		else $error("no clock after start");
	chk_stop_no_ack: assert property (s_stop |-> !sda_tgt_oe)
		else $error("target drives at stop");
	// clocks since scl last changed, saturating
	localparam int LOW_MIN  = 52;
	localparam int HIGH_MIN = 24;
	logic [7:0] run_r;
	logic       scl_d_r;
	always_ff @(posedge clock) begin
		scl_d_r <= scl;
		if (rst | (scl != scl_d_r))
			run_r <= 8'h01;
		else if (run_r != 8'hff)
			run_r <= run_r + 8'h01;
	end

	// clock phases long enough for the fast rate
	chk_scl_low_span: assert property ($rose(scl) |-> run_r >= LOW_MIN)
		else $error("clock low too short");
	chk_scl_high_span: assert property ($fell(scl) |-> run_r >= HIGH_MIN)
		else $error("clock high too short");
endmodule // rail_link_assertions

`default_nettype wire

// file: dual_rail_level_write_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dual_rail_level_write_port_tb;
	logic        clock;
	logic        rst;
	logic        standby;
	logic        wr;
	logic        rd;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] v;
	logic [4:0]  pos_a, neg_a, pos_b, neg_b;
	logic [7:0]  mode_a, mode_b;
	logic        lw_a;
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;
	int          lw_cnt = 0;

	rail_link_if link();
	rail_link_if l2();

	// controller and target joined on the main link
	rail_controller i_rail_controller (.clock(clock), .rst(rst), .ce(1'b1),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.link(link));
	rail_target i_rail_target (.clock(clock), .rst(rst), .ce(1'b1),
		.standby(standby), .link(link), .positive_rail(pos_a),
		.negative_rail(neg_a), .mode_bits(mode_a), .level_write(lw_a));
	// second target driven bit by bit from here
	rail_target #(.HIGH_DEFAULT(1'b1)) i_rail_target_b (.clock(clock),
		.rst(rst), .ce(1'b1), .standby(standby), .link(l2),
		.positive_rail(pos_b), .negative_rail(neg_b), .mode_bits(mode_b),
		.level_write());
	rail_link_assertions i_rail_link_assertions (.clock(clock), .rst(rst),
		.scl(link.scl), .sda(link.sda), .scl_oe(link.scl_oe),
		.sda_ctl_oe(link.sda_ctl_oe), .sda_tgt_oe(link.sda_tgt_oe));

	// 40 MHz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic close_out;
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// level write pulses and hang guard
	always @(posedge clock) begin
		cyc++;
		if (lw_a === 1'b1)
			lw_cnt++;
		if (cyc == 40000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// register port accesses
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clock);
	endtask
	// one command, poll busy, check the nack flag
	task automatic send(input logic [7:0] s, input logic [7:0] d,
		input logic nk);
		wr_reg(8'h00, {16'h0, d, s});
		do rd_reg(8'h04, v); while (v[0] !== 1'b0);
		cmp(32'(v[1]), 32'(nk));
	endtask

	// one quarter of a bit on the second link
	task automatic bq(input logic c, input logic d);
		l2.scl_oe <= c;
		l2.sda_ctl_oe <= d;
		repeat (27) @(posedge clock);
	endtask
	task automatic bstart;
		bq(1'b0, 1'b1);
		bq(1'b1, 1'b1);
	endtask
	task automatic bstop;
		bq(1'b1, 1'b1);
		bq(1'b0, 1'b1);
		bq(1'b0, 1'b0);
		bq(1'b0, 1'b0);
	endtask
	// eight bits msb first, then a released ack slot
	task automatic bb(input logic [7:0] b, input logic exp);
		logic [8:0] x;
		logic d;
		logic a;
		x = {b, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			d = !x[i];
			bq(1'b1, d);
			bq(1'b0, d);
			a = !l2.sda;
			bq(1'b0, d);
			bq(1'b1, d);
		end
		cmp(32'(a), 32'(exp));
	endtask

	initial begin
		rst = 1'b1;
		standby = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		l2.scl_o = 1'b0;
		l2.sda_ctl_o = 1'b0;
		l2.scl_oe = 1'b0;
		l2.sda_ctl_oe = 1'b0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		cmp(32'(pos_a), 32'h0a);
		cmp(32'(neg_b), 32'h0e);
		cmp(32'(mode_a), 32'h03);
		rd_reg(8'h08, v);
		cmp(v, 32'h0);
		// writes through the controller
		// rail enables not modelled; taken as settled well past 45 ms
		send(8'h01, 8'h11, 1'b0);
		send(8'h00, 8'he1, 1'b0);
		send(8'h03, 8'h07, 1'b0);
		send(8'h02, 8'h05, 1'b0);
		cmp(32'(neg_a), 32'h11);
		cmp(32'(pos_a), 32'h01);
		cmp(32'(mode_a), 32'h07);
		cmp(32'(lw_cnt), 32'h2);
		// port ignores the bus in standby
		standby <= 1'b1;
		send(8'h00, 8'h05, 1'b1);
		cmp(32'(pos_a), 32'h01);
		standby <= 1'b0;
		// refused address bytes
		bstart;
		bb(8'h7d, 1'b0);
		bstop;
		bstart;
		bb(8'h7e, 1'b0);
		bstop;
		// burst with sub-address increment
		bstart;
		bb(8'h7c, 1'b1);
		bb(8'h00, 1'b1);
		bb(8'h0c, 1'b1);
		bb(8'h0d, 1'b1);
		bb(8'h13, 1'b1);
		bb(8'h17, 1'b1);
		bstop;
		cmp(32'(pos_b), 32'h0c);
		cmp(32'(neg_b), 32'h0d);
		cmp(32'(mode_b), 32'h17);
		// default codes written back before the rails go off
		send(8'h00, 8'h0a, 1'b0);
		send(8'h01, 8'h0a, 1'b0);
		cmp(32'(pos_a), 32'h0a);
		cmp(32'(neg_a), 32'h0a);
		// second reset restores defaults
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		cmp(32'(pos_a), 32'h0a);
		cmp(32'(mode_a), 32'h03);
		close_out();
	end
endmodule // dual_rail_level_write_port_tb

`default_nettype wire
